// ===== rtl/msmo_pkg.sv
// constants for the monitor scaling and analog meter output block
// Behaviour
// - run hours grow only after a full hour of drive running is counted.
// - reading the run hour clear setting always returns 9999.
// - writing 9999 to the run hour clear setting keeps run hours.
// - digit select 0 rounds decimal monitors to integers; 9999 does nothing.
// - in integer mode, monitor values below 0.99 show as zero.
// - digit select 1 drops hundredths; whole unit monitors pass unchanged.
// - panel selections 20 and 23 are never reformatted by digit select.
// - frequency full scale takes 0 to 400 Hz, starts at 60 Hz.
// - current full scale takes 0 to 500 A, starts at rated current.
// - meter code follows frequency, maximum at frequency full scale.
// - meter code follows current, maximum at current full scale.
// - full scales and gain trim reachable only while view select is 0.
// - full scales writable while running, whatever write protect says.
// - gain trim scales the meter ratio but never passes maximum code.
// - meter item 21 drives the fixed full scale reference level.
// - gain trim writes are accepted while the drive is running.
// - energization hours step hourly; run time pauses while stopped.
`default_nettype none

package msmo_pkg;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] OFS_DIGSEL  = 8'h00;
  localparam logic [7:0] OFS_FREQFS  = 8'h04;
  localparam logic [7:0] OFS_CURFS   = 8'h08;
  localparam logic [7:0] OFS_GAIN    = 8'h0c;
  localparam logic [7:0] OFS_ITEMSEL = 8'h10;
  localparam logic [7:0] OFS_VIEWSEL = 8'h14;
  localparam logic [7:0] OFS_WPSEL   = 8'h18;
  localparam logic [7:0] OFS_RUNCLR  = 8'h1c;
  localparam logic [7:0] OFS_ENHRS   = 8'h20;
  localparam logic [7:0] OFS_RUNHRS  = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;

  // ***************************************************************
  // setting values and reset values
  // ***************************************************************
  localparam logic [15:0] VAL_NOFUNC  = 16'h270f;
  localparam logic [15:0] DIG_INT     = 16'h0000;
  localparam logic [15:0] DIG_TENTH   = 16'h0001;
  localparam logic [15:0] DIGSEL_RST  = VAL_NOFUNC;
  localparam logic [15:0] RUNCLR_DO   = 16'h0000;
  localparam logic [15:0] FREQFS_MAX  = 16'h9c40;
  localparam logic [15:0] FREQFS_RST  = 16'h1770;
  localparam logic [15:0] CURFS_MAX   = 16'hc350;
  localparam logic [15:0] GAIN_ONE    = 16'h1000;
  localparam logic [15:0] GAIN_MAX    = 16'h2000;
  localparam int          GAIN_SHIFT  = 12;
  localparam logic [7:0]  ITEM_FREQ   = 8'h01;
  localparam logic [7:0]  ITEM_CURR   = 8'h02;
  localparam logic [7:0]  ITEM_REF    = 8'h15;
  localparam logic [7:0]  ITEMSEL_RST = ITEM_FREQ;
  localparam logic [7:0]  PANEL_ENERG = 8'h14;
  localparam logic [7:0]  PANEL_RUNT  = 8'h17;
  localparam logic [15:0] VIEW_ALL    = 16'h0000;
  localparam logic [15:0] VIEWSEL_RST = VIEW_ALL;
  localparam logic [1:0]  WP_STOPPED  = 2'h0;
  localparam logic [1:0]  WP_LOCK     = 2'h1;
  localparam logic [1:0]  WP_FREE     = 2'h2;
  localparam logic [1:0]  WPSEL_RST   = WP_STOPPED;
  localparam logic [1:0]  DEC0        = 2'h0;
  localparam logic [1:0]  DEC1        = 2'h1;
  localparam logic [1:0]  DEC2        = 2'h2;
  localparam logic [15:0] LIM_DEC1    = 16'h000a;
  localparam logic [15:0] LIM_DEC2    = 16'h0063;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned HOUR_S        = 3600;

endpackage

`default_nettype wire

// ===== rtl/msmo_scale.sv
// meter output scaling stage with gain trim and saturation
`default_nettype none

module msmo_scale
  import msmo_pkg::*;
#(
  parameter int METER_W = 12
) (
  input  wire logic               clk,
  input  wire logic               rstN,
  input  wire logic [15:0]        value,
  input  wire logic [15:0]        fullScale,
  input  wire logic [15:0]        gain,
  input  wire logic               refMode,
  output logic      [METER_W-1:0] code
);

  localparam logic [METER_W-1:0] FULL = {METER_W{1'b1}};

  logic [31:0]        quot;
  logic [METER_W-1:0] ratio;
  logic [31:0]        trimmed;
  logic [METER_W-1:0] code_next;

  // ***************************************************************
  // ratio and trim
  // ***************************************************************
  always_comb begin
    quot = 32'h0;
    if (refMode) begin
      ratio = FULL;
    end else if (fullScale == 16'h0000) begin
      ratio = (value != 16'h0000) ? FULL : '0;
    end else begin
      quot = (32'(value) * 32'(FULL)) / 32'(fullScale);
      ratio = (quot > 32'(FULL)) ? FULL : quot[METER_W-1:0];
    end
    trimmed = (32'(ratio) * 32'(gain)) >> GAIN_SHIFT;
    code_next = (trimmed > 32'(FULL)) ? FULL : trimmed[METER_W-1:0];
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      code <= '0;
    end else begin
      code <= code_next;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  AST_SAT_OVER:
  assert property (!refMode && fullScale != 16'h0000 && value >= fullScale && gain >= GAIN_ONE
                   |=> code == FULL)
    else $error("meter code not saturated above full scale");

  AST_FULL_AT_REF:
  assert property (!refMode && fullScale != 16'h0000 && value == fullScale && gain == GAIN_ONE
                   |=> code == FULL)
    else $error("meter code not maximum at full scale");

  AST_ZERO_IN:
  assert property (!refMode && value == 16'h0000 |=> code == '0)
    else $error("meter code not zero for zero monitor");

  AST_HALF_TRIM:
  assert property (refMode && gain == 16'h0800 |=> code == (FULL >> 1))
    else $error("gain trim does not halve the reference level");

endmodule

`default_nettype wire

// ===== rtl/msmo_top.sv
// monitor display rounding, run hour counters and analog meter output with APB registers
//
// Design decisions made here: the placing of the registers and the APB register port.
`default_nettype none

module msmo_top
  import msmo_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P  = SEC_CYCLES,
  parameter int unsigned HOUR_SECS_P   = HOUR_S,
  parameter logic [15:0] RATED_CURRENT = 16'h01f4,
  parameter int          METER_W       = 12
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic      [31:0]        prdata,
  output logic                    pslverr,
  input  wire logic               driveRunning,
  input  wire logic [15:0]        freqMonitor,
  input  wire logic [15:0]        currentMonitor,
  input  wire logic [15:0]        monitorValue,
  input  wire logic [1:0]         monitorDecimals,
  input  wire logic [7:0]         panelMonitorSelect,
  output logic      [15:0]        displayValue,
  output logic      [1:0]         displayDecimals,
  output logic      [METER_W-1:0] analogMeterOutput
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (METER_W < 4 || METER_W > 16) begin : g_bad_meter
    $error("METER_W must lie in 4..16");
  end
  if (SEC_CYCLES_P < 2) begin : g_bad_sec
    $error("SEC_CYCLES_P must be at least 2");
  end
  if (HOUR_SECS_P < 2 || HOUR_SECS_P > 4095) begin : g_bad_hour
    $error("HOUR_SECS_P must lie in 2..4095");
  end

  localparam logic [31:0] SEC_LAST  = 32'(SEC_CYCLES_P - 1);
  localparam logic [11:0] HOUR_LAST = 12'(HOUR_SECS_P - 1);

  function automatic logic paramWritable(input logic [1:0] wp, input logic running);
    return (wp == WP_FREE) || (wp == WP_STOPPED && !running);
  endfunction

  function automatic logic [15:0] roundInt(input logic [15:0] v, input logic [1:0] d);
    logic [16:0] sum;
    sum = 17'h00000;
    if (d == DEC2) begin
      sum = (17'(v) + 17'h00032) / 17'h00064;
      return (v < LIM_DEC2) ? 16'h0000 : sum[15:0];
    end else if (d == DEC1) begin
      sum = (17'(v) + 17'h00005) / 17'h0000a;
      return (v < LIM_DEC1) ? 16'h0000 : sum[15:0];
    end
    return v;
  endfunction

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rstSync1_reg;
  logic rstSync2_reg;
  logic rstN;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  assign rstN = rstSync2_reg;

  // ***************************************************************
  // register state
  // ***************************************************************
  logic [15:0] digSel_reg;
  logic [15:0] freqFs_reg;
  logic [15:0] curFs_reg;
  logic [15:0] gain_reg;
  logic [7:0]  itemSel_reg;
  logic [15:0] viewSel_reg;
  logic [1:0]  wpSel_reg;
  logic [31:0] cycCnt_reg;
  logic [11:0] enSec_reg;
  logic [15:0] enHours_reg;
  logic [11:0] runSec_reg;
  logic [15:0] runHours_reg;
  logic [31:0] prdata_reg;

  logic        setup;
  logic        access;
  logic        wrEn;
  logic        wrOk;
  logic        rdOk;
  logic [31:0] rdData;
  logic [15:0] w16;
  logic        fsOpen;
  logic        opOpen;
  logic        runClrWr;
  logic        secTick;
  logic        runHourTick;

  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign wrEn     = access & pwrite;
  assign w16      = pwdata[15:0];
  assign fsOpen   = (viewSel_reg == VIEW_ALL);
  assign opOpen   = paramWritable(wpSel_reg, driveRunning);
  assign runClrWr = wrEn && wrOk && (paddr == OFS_RUNCLR) && (w16 == RUNCLR_DO);

  // ***************************************************************
  // APB decode
  // ***************************************************************
  always_comb begin
    wrOk = 1'b0;
    if (paddr == OFS_DIGSEL) begin
      wrOk = opOpen && (w16 == DIG_INT || w16 == DIG_TENTH || w16 == VAL_NOFUNC);
    end else if (paddr == OFS_FREQFS) begin
      wrOk = fsOpen && (w16 <= FREQFS_MAX);
    end else if (paddr == OFS_CURFS) begin
      wrOk = fsOpen && (w16 <= CURFS_MAX);
    end else if (paddr == OFS_GAIN) begin
      wrOk = fsOpen && (w16 <= GAIN_MAX);
    end else if (paddr == OFS_ITEMSEL) begin
      wrOk = opOpen;
    end else if (paddr == OFS_VIEWSEL) begin
      wrOk = 1'b1;
    end else if (paddr == OFS_WPSEL) begin
      wrOk = (w16 <= {14'h0000, WP_FREE});
    end else if (paddr == OFS_RUNCLR) begin
      wrOk = (w16 == RUNCLR_DO) || (w16 == VAL_NOFUNC);
    end
  end

  always_comb begin
    rdOk   = 1'b1;
    rdData = 32'h00000000;
    if (paddr == OFS_DIGSEL) begin
      rdData = {16'h0000, digSel_reg};
    end else if (paddr == OFS_FREQFS) begin
      rdOk   = fsOpen;
      rdData = fsOpen ? {16'h0000, freqFs_reg} : 32'h00000000;
    end else if (paddr == OFS_CURFS) begin
      rdOk   = fsOpen;
      rdData = fsOpen ? {16'h0000, curFs_reg} : 32'h00000000;
    end else if (paddr == OFS_GAIN) begin
      rdOk   = fsOpen;
      rdData = fsOpen ? {16'h0000, gain_reg} : 32'h00000000;
    end else if (paddr == OFS_ITEMSEL) begin
      rdData = {24'h000000, itemSel_reg};
    end else if (paddr == OFS_VIEWSEL) begin
      rdData = {16'h0000, viewSel_reg};
    end else if (paddr == OFS_WPSEL) begin
      rdData = {30'h00000000, wpSel_reg};
    end else if (paddr == OFS_RUNCLR) begin
      rdData = {16'h0000, VAL_NOFUNC};
    end else if (paddr == OFS_ENHRS) begin
      rdData = {16'h0000, enHours_reg};
    end else if (paddr == OFS_RUNHRS) begin
      rdData = {16'h0000, runHours_reg};
    end else if (paddr == OFS_STATUS) begin
      rdData = {15'h0000, driveRunning, 16'(analogMeterOutput)};
    end else begin
      rdOk = 1'b0;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access & (pwrite ? ~wrOk : ~rdOk);
  assign prdata  = prdata_reg;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prdata_reg <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_reg <= rdData;
    end
  end

  // ***************************************************************
  // settings
  // ***************************************************************
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      digSel_reg  <= DIGSEL_RST;
      itemSel_reg <= ITEMSEL_RST;
      viewSel_reg <= VIEWSEL_RST;
      wpSel_reg   <= WPSEL_RST;
    end else if (wrEn && wrOk) begin
      if (paddr == OFS_DIGSEL) begin
        digSel_reg <= w16;
      end
      if (paddr == OFS_ITEMSEL) begin
        itemSel_reg <= pwdata[7:0];
      end
      if (paddr == OFS_VIEWSEL) begin
        viewSel_reg <= w16;
      end
      if (paddr == OFS_WPSEL) begin
        wpSel_reg <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      freqFs_reg <= FREQFS_RST;
      curFs_reg  <= RATED_CURRENT;
    end else if (wrEn && wrOk) begin
      if (paddr == OFS_FREQFS) begin
        freqFs_reg <= w16;
      end
      if (paddr == OFS_CURFS) begin
        curFs_reg <= w16;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      gain_reg <= GAIN_ONE;
    end else if (wrEn && wrOk && paddr == OFS_GAIN) begin
      gain_reg <= w16;
    end
  end

  // ***************************************************************
  // hour counters
  // ***************************************************************
  assign secTick     = (cycCnt_reg == SEC_LAST);
  assign runHourTick = secTick && driveRunning && (runSec_reg == HOUR_LAST);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cycCnt_reg <= 32'h00000000;
    end else begin
      cycCnt_reg <= secTick ? 32'h00000000 : cycCnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      enSec_reg   <= 12'h000;
      enHours_reg <= 16'h0000;
    end else if (secTick) begin
      if (enSec_reg == HOUR_LAST) begin
        enSec_reg   <= 12'h000;
        enHours_reg <= enHours_reg + 16'h0001;
      end else begin
        enSec_reg <= enSec_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      runSec_reg   <= 12'h000;
      runHours_reg <= 16'h0000;
    end else if (runClrWr) begin
      runSec_reg   <= 12'h000;
      runHours_reg <= 16'h0000;
    end else if (runHourTick) begin
      runSec_reg   <= 12'h000;
      runHours_reg <= runHours_reg + 16'h0001;
    end else if (secTick && driveRunning) begin
      runSec_reg <= runSec_reg + 12'h001;
    end
  end

  // ***************************************************************
  // panel display formatting
  // ***************************************************************
  logic [15:0] displayValue_next;
  logic [1:0]  displayDecimals_next;

  always_comb begin
    displayValue_next    = monitorValue;
    displayDecimals_next = monitorDecimals;
    if (panelMonitorSelect == PANEL_ENERG || panelMonitorSelect == PANEL_RUNT) begin
      displayValue_next    = monitorValue;
      displayDecimals_next = monitorDecimals;
    end else if (digSel_reg == DIG_INT && monitorDecimals != DEC0) begin
      displayValue_next    = roundInt(monitorValue, monitorDecimals);
      displayDecimals_next = DEC0;
    end else if (digSel_reg == DIG_TENTH && monitorDecimals == DEC2) begin
      displayValue_next    = monitorValue / 16'h000a;
      displayDecimals_next = DEC1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      displayValue    <= 16'h0000;
      displayDecimals <= DEC0;
    end else begin
      displayValue    <= displayValue_next;
      displayDecimals <= displayDecimals_next;
    end
  end

  // ***************************************************************
  // meter item selection
  // ***************************************************************
  logic [15:0] meterValue;
  logic [15:0] meterFs;
  logic        meterRef;

  always_comb begin
    meterValue = 16'h0000;
    meterFs    = 16'h0000;
    meterRef   = 1'b0;
    case (itemSel_reg)
      ITEM_FREQ: begin
        meterValue = freqMonitor;
        meterFs    = freqFs_reg;
      end
      ITEM_CURR: begin
        meterValue = currentMonitor;
        meterFs    = curFs_reg;
      end
      ITEM_REF: begin
        meterRef = 1'b1;
      end
      default: begin
        meterValue = 16'h0000;
      end
    endcase
  end

  msmo_scale #(
    .METER_W(METER_W)
  ) u_scale (
    .clk      (clk),
    .rstN     (rstN),
    .value    (meterValue),
    .fullScale(meterFs),
    .gain     (gain_reg),
    .refMode  (meterRef),
    .code     (analogMeterOutput)
  );

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  AST_RUNCLR_READ:
  assert property (setup && !pwrite && paddr == OFS_RUNCLR |=> prdata == {16'h0000, VAL_NOFUNC})
    else $error("clear setting did not read 9999");

  AST_KEEP_9999:
  assert property (wrEn && paddr == OFS_RUNCLR && w16 == VAL_NOFUNC && !runHourTick
                   |=> $stable(runHours_reg))
    else $error("writing 9999 changed run hours");

  AST_RUN_WHOLE:
  assert property ($changed(runHours_reg) && !$past(runClrWr)
                   |-> $past(runSec_reg) == HOUR_LAST && $past(driveRunning))
    else $error("run hours grew without a full running hour");

  AST_RUN_PAUSE:
  assert property (!driveRunning && !runClrWr |=> $stable(runSec_reg) && $stable(runHours_reg))
    else $error("run time advanced while stopped");

  AST_NOFUNC:
  assert property (digSel_reg == VAL_NOFUNC
                   |=> displayValue == $past(monitorValue)
                       && displayDecimals == $past(monitorDecimals))
    else $error("digit select 9999 changed the display");

  AST_BELOW_ONE:
  assert property (digSel_reg == DIG_INT && monitorDecimals == DEC2 && monitorValue < LIM_DEC2
                   && panelMonitorSelect != PANEL_ENERG && panelMonitorSelect != PANEL_RUNT
                   |=> displayValue == 16'h0000 && displayDecimals == DEC0)
    else $error("value below 0.99 not shown as zero");

  AST_TENTHS:
  assert property (digSel_reg == DIG_TENTH && monitorDecimals == DEC2
                   && panelMonitorSelect != PANEL_ENERG && panelMonitorSelect != PANEL_RUNT
                   |=> displayValue == $past(monitorValue) / 16'h000a && displayDecimals == DEC1)
    else $error("hundredths not dropped");

  AST_TIME_KEEP:
  assert property (panelMonitorSelect == PANEL_RUNT |=> displayValue == $past(monitorValue))
    else $error("time monitor was reformatted");

  AST_VIEW_LOCK:
  assert property (wrEn && !fsOpen
                   |=> $stable(freqFs_reg) && $stable(curFs_reg) && $stable(gain_reg))
    else $error("full scale changed while hidden");

  AST_FS_WRITE:
  assert property (wrEn && paddr == OFS_FREQFS && fsOpen && w16 <= FREQFS_MAX
                   |=> freqFs_reg == 16'($past(pwdata)))
    else $error("frequency full scale write lost");

  AST_CUR_RANGE:
  assert property (curFs_reg <= CURFS_MAX || curFs_reg == RATED_CURRENT)
    else $error("current full scale out of range");

  AST_GAIN_RUN:
  assert property (wrEn && paddr == OFS_GAIN && fsOpen && w16 <= GAIN_MAX && driveRunning
                   |=> gain_reg == 16'($past(pwdata)))
    else $error("gain trim refused while running");

  AST_REF_OUT:
  assert property (itemSel_reg == ITEM_REF && gain_reg == GAIN_ONE |=> analogMeterOutput == '1)
    else $error("reference item did not give full level");

  CVR_RUN_HOUR:  cover property (runHourTick);
  CVR_REF_ITEM:  cover property (itemSel_reg == ITEM_REF ##1 itemSel_reg == ITEM_CURR);
  CVR_ROUND_INT: cover property (digSel_reg == DIG_INT && monitorDecimals == DEC2);
  CVR_RUN_CLEAR: cover property (runClrWr);

endmodule

`default_nettype wire

// ===== bench/msmo_meter.sv
// analog panel meter model driven by the meter code
`default_nettype none
module msmo_meter #(
  parameter int METER_W = 12
) (
  input  wire logic [METER_W-1:0] code,
  output logic      [15:0]        milliVolts
);
  timeunit 1ns;
  timeprecision 1ps;
  // all ones reads as 10 V
  assign milliVolts = 16'((32'(code) * 10000) / ((1 << METER_W) - 1));
endmodule
`default_nettype wire

// ===== bench/msmo_top_tb.sv
// self-checking bench for the monitor scaling and meter block
`default_nettype none
module msmo_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import msmo_pkg::*;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, driveRunning = 0;
  logic [7:0]  paddr = 0, panelMonitorSelect = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] freqMonitor = 0, currentMonitor = 0, monitorValue = 0, displayValue;
  logic [1:0]  monitorDecimals = 0, displayDecimals;
  logic [15:0] milliVolts;
  logic [11:0] analogMeterOutput;
  logic        pready, pslverr;
  int          n_errors = 0, total_checks = 0;
  always #4 clk = ~clk;
  msmo_top #(.SEC_CYCLES_P(4), .HOUR_SECS_P(3)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .driveRunning(driveRunning),
    .freqMonitor(freqMonitor), .currentMonitor(currentMonitor), .monitorValue(monitorValue),
    .monitorDecimals(monitorDecimals), .panelMonitorSelect(panelMonitorSelect),
    .displayValue(displayValue), .displayDecimals(displayDecimals),
    .analogMeterOutput(analogMeterOutput));
  msmo_meter meter (.code(analogMeterOutput), .milliVolts(milliVolts));
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      n_errors++;
      give_verdict();
    end
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
    chk("pslverr", 32'(ee), 32'(e));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] r;
    logic e;
    apb(0, a, 0, r, e);
    chk("prdata", x, r);
    chk("pslverr", 32'(ee), 32'(e));
  endtask
  task automatic meter_is(input logic [11:0] x);
    repeat (3) @(posedge clk);
    chk("meter", 32'(x), 32'(analogMeterOutput));
  endtask
  task automatic disp(input logic [7:0] s, input logic [15:0] v, input logic [1:0] d,
                      input logic [15:0] xv, input logic [1:0] xd);
    panelMonitorSelect <= s; monitorValue <= v; monitorDecimals <= d;
    repeat (3) @(posedge clk);
    chk("display", 32'(xv), 32'(displayValue));
    chk("decimals", 32'(xd), 32'(displayDecimals));
  endtask
  task automatic meter_scen();
    freqMonitor <= 16'h0bb8;
    meter_is(12'h7ff);
    freqMonitor <= 16'h2328;
    meter_is(12'hfff);
    wr(OFS_ITEMSEL, 32'h02, 0);
    currentMonitor <= 16'h00fa;
    meter_is(12'h7ff);
    wr(OFS_ITEMSEL, 32'h15, 0);
    meter_is(12'hfff);
    chk("millivolts", 32'h00002710, 32'(milliVolts));
    driveRunning <= 1;
    wr(OFS_GAIN, 32'h0800, 0);
    meter_is(12'h7ff);
    wr(OFS_GAIN, 32'h2001, 1);
    wr(OFS_GAIN, 32'h2000, 0);
    meter_is(12'hfff);
    wr(OFS_FREQFS, 32'h9c41, 1);
    wr(OFS_FREQFS, 32'h2ee0, 0);
    driveRunning <= 0;
    wr(OFS_ITEMSEL, 32'h02, 0);
    meter_is(12'hffe);
  endtask
  task automatic disp_scen();
    wr(OFS_DIGSEL, 32'h0, 0);
    disp(8'h01, 16'h0062, 2'h2, 16'h0, 2'h0);
    disp(8'h01, 16'h0009, 2'h1, 16'h0, 2'h0);
    disp(8'h01, 16'h0019, 2'h1, 16'h0003, 2'h0);
    disp(8'h01, 16'h04e2, 2'h2, 16'h000d, 2'h0);
    disp(8'h14, 16'h04e2, 2'h2, 16'h04e2, 2'h2);
    wr(OFS_DIGSEL, 32'h1, 0);
    disp(8'h01, 16'h04e9, 2'h2, 16'h007d, 2'h1);
    disp(8'h01, 16'h04e9, 2'h0, 16'h04e9, 2'h0);
  endtask
  task automatic hour_scen();
    logic [31:0] r1, r2;
    logic        e;
    wr(OFS_RUNCLR, 32'h0, 0);
    driveRunning <= 1;
    repeat (8) @(posedge clk);
    driveRunning <= 0;
    rd(OFS_RUNHRS, 32'h0, 0);
    driveRunning <= 1;
    repeat (40) @(posedge clk);
    driveRunning <= 0;
    rd(OFS_RUNHRS, 32'h4, 0);
    wr(OFS_RUNCLR, 32'h270f, 0);
    rd(OFS_RUNHRS, 32'h4, 0);
    wr(OFS_RUNCLR, 32'h0, 0);
    rd(OFS_RUNCLR, 32'h270f, 0);
    rd(OFS_RUNHRS, 32'h0, 0);
    apb(0, OFS_ENHRS, 0, r1, e);
    repeat (9) @(posedge clk);
    apb(0, OFS_ENHRS, 0, r2, e);
    chk("enhours", r1 + 32'h1, r2);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    rd(OFS_DIGSEL, 32'h270f, 0);
    rd(OFS_FREQFS, 32'h1770, 0);
    rd(OFS_CURFS, 32'h01f4, 0);
    meter_scen();
    disp_scen();
    hour_scen();
    wr(OFS_VIEWSEL, 32'h1, 0);
    wr(OFS_GAIN, 32'h1000, 1);
    rd(OFS_FREQFS, 32'h0, 1);
    wr(OFS_VIEWSEL, 32'h0, 0);
    wr(OFS_WPSEL, 32'h1, 0);
    wr(OFS_DIGSEL, 32'h0, 1);
    wr(OFS_CURFS, 32'h03e8, 0);
    rd(OFS_CURFS, 32'h03e8, 0);
    wr(OFS_CURFS, 32'hc351, 1);
    wr(OFS_WPSEL, 32'h2, 0);
    wr(OFS_DIGSEL, 32'h270f, 0);
    wr(8'h3c, 32'h1, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
